// [src/crate_cmd_defines.svh]
/*
  Constants for the crate command decoder and setup verifier: dataway
  function codes, setup byte offsets, check limits, status bits, timing.
  Assumes the including file has a timescale of its own.
*/
`ifndef CRATE_CMD_DEFINES_SVH
`define CRATE_CMD_DEFINES_SVH

// Dataway function codes
`define FN_READ       5'h02
`define FN_IDENT      5'h03
`define FN_TEST_LAM   5'h08
`define FN_ARM_RESET  5'h09
`define FN_CLEAR_LAM  5'h0A
`define FN_TEST_LOCK  5'h0B
`define FN_VERIFY     5'h12
`define FN_DIS_LAM    5'h18
`define FN_TRIG_ABORT 5'h19
`define FN_EN_LAM     5'h1A
`define FN_TEST_RAW   5'h1B
`define SUB_STATUS    4'h6

// Setup byte offsets
`define SU_TS_RES     6'h00
`define SU_GAIN1      6'h01
`define SU_BLOCK      6'h05
`define SU_HOLDOFF    6'h08
`define SU_SLOPE      6'h09
`define SU_TCOUPLE    6'h0A
`define SU_LEVEL_HI   6'h0B
`define SU_LEVEL_LO   6'h0C
`define SU_TSOURCE    6'h0D
`define SU_PTN_LO     6'h0E
`define SU_PTN_HI     6'h0F
`define SU_CHANS      6'h10
`define SU_CCOUPLE1   6'h15
`define SU_SPS        6'h1A
`define SU_SEG_LO     6'h1B
`define SU_SEG_HI     6'h1C
`define SU_DUAL       6'h1D
`define SU_RATE1      6'h1E
`define SU_RATE2      6'h1F
`define SU_MEMSIZE    6'h20
`define SU_STATUS     6'h21
`define SU_CHECKSUM   6'h22
`define SU_LEDS       6'h23
`define SU_BYTES      36

// Check limits and defaults
`define RATE_MAX      8'h11
`define RATE_EXT      8'h00
`define RATE_5MHZ     8'h01
`define RATE_2MHZ     8'h02
`define SPS_MAX       8'h0D
`define MEM_MAX       8'h10
`define DUAL_MAX      8'h03
`define SEG_MAX       16'h0400
`define PTN_MIN       16'h0004
`define PTN_DEFAULT   16'h0064
`define SLOPE_WINDOW  8'h02
`define SLOPE_HYST    8'h03
`define LED_OK        8'h10
`define LED_ARMED     8'h20

// Status bits
`define ST_ILLEGAL    0
`define ST_TOGGLE     2
`define ST_SEGSIZE    5
`define ST_LEVELS     6

// Timing
`define CLK_MHZ         50
`define ARM_TIME_US     2000
`define VERIFY_TIME_US  3000
`define RESET_TIME_US   100000
`define IDENT_CODE      12'h0_5A5

`endif

// [src/crate_cmd_pkg.sv]
/*
  Types for the crate command decoder and setup verifier.
  Assumes crate_cmd_defines.svh is on the include path.
*/
package crate_cmd_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ARM_WAIT, ST_ARM_SYNC, ST_RESET_WAIT,
    ST_V_RANGE, ST_V_CHAN, ST_V_F2, ST_V_SEG, ST_V_PTN,
    ST_V_SIZE, ST_V_TOGGLE, ST_V_LEVELS, ST_V_SUM, ST_V_WAIT
  } seq_t;

  typedef struct packed {
    logic [35:0][7:0] mem;
    logic [5:0]       rd_ptr;
    seq_t             seq;
    logic [22:0]      timer;
    logic [5:0]       idx;
    logic [7:0]       sum;
    logic [7:0]       status;
    logic             lam;
    logic             lam_en;
    logic             lockout;
    logic             armed;
    logic             setup_ok;
    logic             counter_en;
    logic             q;
    logic             x;
    logic [11:0]      r;
    logic             lam_line;
    logic             trig;
    logic             cclk;
  } state_t;

endpackage

// [src/crate_cmd_setup_verifier.sv]
/*
  Dataway command decoder with setup memory and setup verification engine.
  Assumes one command per STROBE_IN pulse, station already addressed on
  N_IN, and acquisition hardware that pulses ACQ_DONE_IN and SAMPLE_CLK_IN.
*/
`timescale 1ns/100ps
`include "crate_cmd_defines.svh"

module crate_cmd_setup_verifier #(
  parameter int ARM_CYCLES    = `ARM_TIME_US * `CLK_MHZ,
  parameter int VERIFY_CYCLES = `VERIFY_TIME_US * `CLK_MHZ,
  parameter int RESET_CYCLES  = `RESET_TIME_US * `CLK_MHZ
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        STROBE_IN,
  input  wire logic        N_IN,
  input  wire logic [4:0]  F_IN,
  input  wire logic [3:0]  A_IN,
  input  wire logic        ACQ_DONE_IN,
  input  wire logic        SAMPLE_CLK_IN,
  input  wire logic        SETUP_WE_IN,
  input  wire logic [5:0]  SETUP_ADDR_IN,
  input  wire logic [7:0]  SETUP_DATA_IN,
  output logic [11:0]      R_OUT,
  output logic             Q_OUT,
  output logic             X_OUT,
  output logic             LAM_OUT,
  output logic             LOCKOUT_OUT,
  output logic             ARMED_LED_OUT,
  output logic             SETUP_OK_LED_OUT,
  output logic             COUNTER_EN_OUT,
  output logic             COUNTER_CLK_OUT,
  output logic             TRIGGER_OUT
);

  crate_cmd_pkg::state_t s_reg;
  crate_cmd_pkg::state_t s_next;

  // Clamp to default when above maximum; bit 8 flags a correction
  function automatic logic [8:0] range_fix(input logic [7:0] v, input logic [7:0] mx, input logic [7:0] df);
    range_fix = (v > mx) ? {1'b1, df} : {1'b0, v};
  endfunction

  logic       go;
  logic [8:0] fx;
  logic [15:0] seg;
  logic [15:0] ptn;
  logic [7:0] mem_log;
  logic [7:0] chan_log;
  logic [7:0] r1;
  logic [7:0] r2;

  // Next-state logic: command decode, then the sequencer
  always_comb
  begin
    s_next         = s_reg;
    s_next.trig    = 1'b0;
    s_next.cclk    = 1'b0;
    go             = STROBE_IN && N_IN;
    fx             = 9'h000;
    seg            = {s_reg.mem[`SU_SEG_HI], s_reg.mem[`SU_SEG_LO]};
    ptn            = {s_reg.mem[`SU_PTN_HI], s_reg.mem[`SU_PTN_LO]};
    mem_log        = (s_reg.mem[`SU_MEMSIZE] == 8'h00) ? `SPS_MAX : s_reg.mem[`SU_MEMSIZE];
    chan_log       = (s_reg.mem[`SU_CHANS] == 8'h04) ? 8'h02 : s_reg.mem[`SU_CHANS] - 8'h01;
    r1             = s_reg.mem[`SU_RATE1];
    r2             = s_reg.mem[`SU_RATE2];
    // Setup bytes loaded from the dataway side when not locked out
    if (SETUP_WE_IN && !s_reg.lockout && SETUP_ADDR_IN < 6'(`SU_BYTES))
      s_next.mem[SETUP_ADDR_IN] = SETUP_DATA_IN;
    if (go)
    begin
      s_next.x = 1'b1;
      s_next.q = 1'b0;
      s_next.r = 12'h0_000;
      unique case (F_IN)
        `FN_IDENT:
        begin
          s_next.r = `IDENT_CODE;
          s_next.q = 1'b1;
        end
        `FN_TEST_LAM:  s_next.q = s_reg.lam && s_reg.lam_en;
        `FN_TEST_RAW:  s_next.q = s_reg.lam;
        `FN_TEST_LOCK: s_next.q = !s_reg.lockout;
        `FN_CLEAR_LAM: s_next.lam = 1'b0;
        `FN_DIS_LAM:   s_next.lam_en = 1'b0;
        `FN_EN_LAM:    s_next.lam_en = 1'b1;
        `FN_ARM_RESET:
        begin
          if (A_IN[0])
          begin
            s_next.seq        = crate_cmd_pkg::ST_RESET_WAIT;
            s_next.lockout    = 1'b1;
            s_next.counter_en = 1'b0;
            s_next.armed      = 1'b0;
            s_next.timer      = 23'h00_0000;
          end
          else if (!s_reg.lockout)
          begin
            s_next.seq     = crate_cmd_pkg::ST_ARM_WAIT;
            s_next.lockout = 1'b1;
            s_next.armed   = 1'b0;
            s_next.timer   = 23'h00_0000;
          end
        end
        `FN_TRIG_ABORT:
        begin
          if (A_IN[0])
            s_next.counter_en = 1'b0;
          else
            s_next.trig = 1'b1;
          s_next.q = 1'b1;
        end
        `FN_READ:
        begin
          if (A_IN == 4'h0)
          begin
            s_next.cclk = 1'b1;
            s_next.q    = s_reg.counter_en;
          end
          else if (A_IN == `SUB_STATUS)
          begin
            s_next.rd_ptr = `SU_STATUS;
            s_next.q      = 1'b1;
          end
          else if (A_IN == 4'h1 && !s_reg.lockout)
          begin
            s_next.r      = {4'h0, s_reg.mem[s_reg.rd_ptr]};
            s_next.q      = 1'b1;
            s_next.rd_ptr = (s_reg.rd_ptr == 6'(`SU_BYTES - 1)) ? 6'h00 : s_reg.rd_ptr + 6'h01;
          end
        end
        `FN_VERIFY:
        begin
          if (A_IN == `SUB_STATUS && !s_reg.lockout)
          begin
            s_next.seq      = crate_cmd_pkg::ST_V_RANGE;
            s_next.lockout  = 1'b1;
            s_next.setup_ok = 1'b1;
            s_next.status   = 8'h00;
            s_next.timer    = 23'h00_0000;
          end
        end
        default: s_next.x = 1'b0;
      endcase
    end
    else if (STROBE_IN)
    begin
      s_next.x = 1'b0;
      s_next.q = 1'b0;
      s_next.r = 12'h0_000;
    end
    // Completion of acquisition sets the request; wins over a clear
    if (ACQ_DONE_IN)
    begin
      s_next.lam        = 1'b1;
      s_next.counter_en = 1'b0;
    end
    if (s_reg.seq != crate_cmd_pkg::ST_IDLE && s_next.seq == s_reg.seq)
      s_next.timer = s_reg.timer + 23'h00_0001;
    // Sequencer for arm, reset and verification; a reset command preempts it
    unique case ((s_next.seq == s_reg.seq) ? s_reg.seq : crate_cmd_pkg::ST_IDLE)
      crate_cmd_pkg::ST_IDLE: ;
      crate_cmd_pkg::ST_ARM_WAIT:
        if (s_reg.timer >= 23'(ARM_CYCLES - 1))
          s_next.seq = crate_cmd_pkg::ST_ARM_SYNC;
      crate_cmd_pkg::ST_ARM_SYNC:
        if (SAMPLE_CLK_IN)
        begin
          s_next.seq        = crate_cmd_pkg::ST_IDLE;
          s_next.lockout    = 1'b0;
          s_next.armed      = 1'b1;
          s_next.counter_en = 1'b1;
          s_next.mem[`SU_LEDS] = (s_reg.setup_ok ? `LED_OK : 8'h00) | `LED_ARMED;
        end
      crate_cmd_pkg::ST_RESET_WAIT:
        if (s_reg.timer >= 23'(RESET_CYCLES - 1))
        begin
          s_next.seq     = crate_cmd_pkg::ST_IDLE;
          s_next.lockout = 1'b0;
          s_next.lam     = ACQ_DONE_IN;
          s_next.lam_en  = 1'b0;
          s_next.rd_ptr  = 6'h00;
        end
      crate_cmd_pkg::ST_V_RANGE:
      begin
        // Zero-based settings checked against their maximum
        for (int i = 0; i < 12; i++)
        begin
          unique case (i)
            0:  fx = range_fix(s_reg.mem[`SU_TS_RES], 8'h04, 8'h04);
            1:  fx = range_fix(s_reg.mem[`SU_SLOPE], 8'h04, 8'h00);
            2:  fx = range_fix(s_reg.mem[`SU_TCOUPLE], 8'h03, 8'h02);
            3:  fx = range_fix(s_reg.mem[`SU_TSOURCE], 8'h03, 8'h00);
            4:  fx = range_fix(s_reg.mem[`SU_SPS], `SPS_MAX, 8'h00);
            5:  fx = range_fix(s_reg.mem[`SU_DUAL], `DUAL_MAX, 8'h00);
            6:  fx = range_fix(s_reg.mem[`SU_RATE1], `RATE_MAX, 8'h0E);
            7:  fx = range_fix(s_reg.mem[`SU_MEMSIZE], `MEM_MAX, 8'h00);
            8:  fx = range_fix(s_reg.mem[`SU_HOLDOFF], 8'h01, 8'h01);
            9:  fx = range_fix(s_reg.mem[`SU_BLOCK], 8'h0C, 8'h02);
            10: fx = 9'h000;
            default: fx = 9'h000;
          endcase
          unique case (i)
            0:  s_next.mem[`SU_TS_RES] = fx[7:0];
            1:  s_next.mem[`SU_SLOPE] = fx[7:0];
            2:  s_next.mem[`SU_TCOUPLE] = fx[7:0];
            3:  s_next.mem[`SU_TSOURCE] = fx[7:0];
            4:  s_next.mem[`SU_SPS] = fx[7:0];
            5:  s_next.mem[`SU_DUAL] = fx[7:0];
            6:  s_next.mem[`SU_RATE1] = fx[7:0];
            7:  s_next.mem[`SU_MEMSIZE] = fx[7:0];
            8:  s_next.mem[`SU_HOLDOFF] = fx[7:0];
            9:  s_next.mem[`SU_BLOCK] = fx[7:0];
            default: ;
          endcase
          if (fx[8])
            s_next.status[`ST_ILLEGAL] = 1'b1;
        end
        // Per-channel gain and input coupling
        for (int c = 0; c < 4; c++)
        begin
          fx = range_fix(s_reg.mem[`SU_GAIN1 + 6'(c)], 8'h07, 8'h04);
          s_next.mem[`SU_GAIN1 + 6'(c)] = fx[7:0];
          if (fx[8])
            s_next.status[`ST_ILLEGAL] = 1'b1;
          fx = range_fix(s_reg.mem[`SU_CCOUPLE1 + 6'(c)], 8'h07, 8'h00);
          s_next.mem[`SU_CCOUPLE1 + 6'(c)] = fx[7:0];
          if (fx[8])
            s_next.status[`ST_ILLEGAL] = 1'b1;
        end
        s_next.seq = crate_cmd_pkg::ST_V_CHAN;
      end
      crate_cmd_pkg::ST_V_CHAN:
      begin
        if (s_reg.mem[`SU_CHANS] != 8'h01 && s_reg.mem[`SU_CHANS] != 8'h02 && s_reg.mem[`SU_CHANS] != 8'h04)
        begin
          s_next.status[`ST_ILLEGAL] = 1'b1;
          s_next.mem[`SU_CHANS] = (s_reg.mem[`SU_CHANS] == 8'h00) ? 8'h01 : 8'h04;
        end
        s_next.seq = crate_cmd_pkg::ST_V_F2;
      end
      crate_cmd_pkg::ST_V_F2:
      begin
        if (r1 != `RATE_EXT && s_reg.mem[`SU_DUAL] != 8'h00 && (r2 == 8'h00 || r2 > `RATE_MAX))
        begin
          s_next.mem[`SU_DUAL] = 8'h00;
          s_next.status[`ST_ILLEGAL] = 1'b1;
        end
        s_next.seq = crate_cmd_pkg::ST_V_SEG;
      end
      crate_cmd_pkg::ST_V_SEG:
      begin
        if (seg == 16'h0000 || seg > `SEG_MAX)
        begin
          s_next.mem[`SU_SEG_LO] = 8'h01;
          s_next.mem[`SU_SEG_HI] = 8'h00;
          s_next.status[`ST_ILLEGAL] = 1'b1;
        end
        s_next.seq = crate_cmd_pkg::ST_V_PTN;
      end
      crate_cmd_pkg::ST_V_PTN:
      begin
        if ((s_reg.mem[`SU_DUAL] == 8'h01 || s_reg.mem[`SU_DUAL] == 8'h03) && ptn < `PTN_MIN)
        begin
          s_next.mem[`SU_PTN_LO] = 8'(`PTN_DEFAULT);
          s_next.mem[`SU_PTN_HI] = 8'h00;
          s_next.status[`ST_ILLEGAL] = 1'b1;
        end
        s_next.seq = crate_cmd_pkg::ST_V_SIZE;
      end
      crate_cmd_pkg::ST_V_SIZE:
      begin
        // Sizes compared as powers of two: 1K samples times 2^code
        if (s_reg.mem[`SU_SPS] + chan_log > mem_log)
        begin
          s_next.mem[`SU_SPS] = mem_log;
          s_next.status[`ST_SEGSIZE] = 1'b1;
        end
        s_next.seq = crate_cmd_pkg::ST_V_TOGGLE;
      end
      crate_cmd_pkg::ST_V_TOGGLE:
      begin
        if (s_reg.mem[`SU_DUAL] != 8'h00 && ((r1 == `RATE_5MHZ && r2 == `RATE_2MHZ) ||
                                             (r1 == `RATE_2MHZ && r2 == `RATE_5MHZ)))
        begin
          s_next.mem[`SU_DUAL] = 8'h00;
          s_next.status[`ST_TOGGLE] = 1'b1;
        end
        s_next.seq = crate_cmd_pkg::ST_V_LEVELS;
      end
      crate_cmd_pkg::ST_V_LEVELS:
      begin
        if ((s_reg.mem[`SU_SLOPE] == `SLOPE_WINDOW || s_reg.mem[`SU_SLOPE] == `SLOPE_HYST) &&
            s_reg.mem[`SU_LEVEL_HI] < s_reg.mem[`SU_LEVEL_LO])
        begin
          s_next.mem[`SU_LEVEL_HI] = s_reg.mem[`SU_LEVEL_LO];
          s_next.mem[`SU_LEVEL_LO] = s_reg.mem[`SU_LEVEL_HI];
          s_next.status[`ST_LEVELS] = 1'b1;
        end
        s_next.idx = 6'h00;
        s_next.sum = 8'h00;
        s_next.seq = crate_cmd_pkg::ST_V_SUM;
      end
      crate_cmd_pkg::ST_V_SUM:
      begin
        // Status byte is stored first so that it joins the sum
        if (s_reg.idx == 6'h00)
          s_next.mem[`SU_STATUS] = s_reg.status & 8'h7F;
        if (s_reg.idx == `SU_CHECKSUM)
        begin
          s_next.mem[`SU_CHECKSUM] = ~s_reg.sum;
          s_next.seq = crate_cmd_pkg::ST_V_WAIT;
        end
        else
        begin
          s_next.sum = s_reg.sum + ((s_reg.idx == `SU_STATUS) ? (s_reg.status & 8'h7F) : s_reg.mem[s_reg.idx]);
          s_next.idx = s_reg.idx + 6'h01;
        end
      end
      crate_cmd_pkg::ST_V_WAIT:
        if (s_reg.timer >= 23'(VERIFY_CYCLES - 1))
        begin
          s_next.seq      = crate_cmd_pkg::ST_IDLE;
          s_next.lockout  = 1'b0;
          s_next.setup_ok = (s_reg.status == 8'h00);
          s_next.rd_ptr   = `SU_STATUS;
          s_next.mem[`SU_LEDS] = ((s_reg.status == 8'h00) ? `LED_OK : 8'h00) | (s_reg.armed ? `LED_ARMED : 8'h00);
        end
    endcase
    s_next.lam_line = s_next.lam && s_next.lam_en;
  end

  // State register with synchronous reset; setup memory keeps its content
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      s_reg     <= '0;
      s_reg.mem <= s_reg.mem;
    end
    else
      s_reg <= s_next;
  end

  // Outputs taken straight from the state register
  assign R_OUT            = s_reg.r;
  assign Q_OUT            = s_reg.q;
  assign X_OUT            = s_reg.x;
  assign LAM_OUT          = s_reg.lam_line;
  assign LOCKOUT_OUT      = s_reg.lockout;
  assign ARMED_LED_OUT    = s_reg.armed;
  assign SETUP_OK_LED_OUT = s_reg.setup_ok;
  assign COUNTER_EN_OUT   = s_reg.counter_en;
  assign COUNTER_CLK_OUT  = s_reg.cclk;
  assign TRIGGER_OUT      = s_reg.trig;

endmodule

// [sim/crate_cmd_assertions.sv]
/*
  Checker for the crate command decoder: answers, request drive, lockout.
  Assumes a bind onto the top module and crate_cmd_defines.svh on the path.
*/
`timescale 1ns/100ps
`include "crate_cmd_defines.svh"
module crate_cmd_assertions #(
  parameter int ARM_CYCLES    = 100,
  parameter int VERIFY_CYCLES = 200,
  parameter int RESET_CYCLES  = 300
) (
  input wire logic        SYS_CLK_IN,
  input wire logic        RESETN_IN,
  input wire logic        STROBE_IN,
  input wire logic        N_IN,
  input wire logic [4:0]  F_IN,
  input wire logic [3:0]  A_IN,
  input wire logic        ACQ_DONE_IN,
  input wire logic        SAMPLE_CLK_IN,
  input wire logic        SETUP_WE_IN,
  input wire logic [5:0]  SETUP_ADDR_IN,
  input wire logic [7:0]  SETUP_DATA_IN,
  input wire logic [11:0] R_OUT,
  input wire logic        Q_OUT,
  input wire logic        X_OUT,
  input wire logic        LAM_OUT,
  input wire logic        LOCKOUT_OUT,
  input wire logic        ARMED_LED_OUT,
  input wire logic        SETUP_OK_LED_OUT,
  input wire logic        COUNTER_EN_OUT,
  input wire logic        COUNTER_CLK_OUT,
  input wire logic        TRIGGER_OUT
);
  // Command taken at this edge and its function/subaddress pair
  wire       take = STROBE_IN && N_IN;
  wire [8:0] fa   = {F_IN, A_IN};

  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  // Answers one cycle after the command is taken; arm completion after a sampling clock
  ident_read_a: assert property (take && fa == {`FN_IDENT, 4'h0} |=> R_OUT == `IDENT_CODE && Q_OUT)
    else $error("identity read answer wrong");
  lam_test_a: assert property (take && fa == {`FN_TEST_LAM, 4'h0} |=> Q_OUT == $past(LAM_OUT))
    else $error("request test does not follow driven request");
  lam_off_a: assert property (take && fa == {`FN_DIS_LAM, 4'h0} |=> !LAM_OUT)
    else $error("request still driven after disable");
  lock_test_a: assert property (take && fa == {`FN_TEST_LOCK, 4'h0} |=> Q_OUT == !$past(LOCKOUT_OUT))
    else $error("lockout test answer wrong");
  trig_cause_a: assert property ($rose(TRIGGER_OUT) |-> $past(take && fa == {`FN_TRIG_ABORT, 4'h0}))
    else $error("trigger pulse without trigger command");
  abort_count_a: assert property (take && fa == {`FN_TRIG_ABORT, 4'h1} |=> !COUNTER_EN_OUT && Q_OUT)
    else $error("abort left counters enabled");
  count_clock_a: assert property (take && fa == {`FN_READ, 4'h0} |=> COUNTER_CLK_OUT)
    else $error("data read gave no counter clock");
  locked_read_a: assert property (take && fa == {`FN_READ, 4'h1} && LOCKOUT_OUT |=> !Q_OUT && R_OUT == 12'h000)
    else $error("byte read answered during lockout");
  verify_lock_a: assert property (take && fa == {`FN_VERIFY, `SUB_STATUS} && !LOCKOUT_OUT |=>
    (LOCKOUT_OUT && SETUP_OK_LED_OUT) [*8])
    else $error("verify did not lock out and light the setup indicator");
  reset_abort_a: assert property (take && fa == {`FN_ARM_RESET, 4'h1} |=>
    LOCKOUT_OUT && !COUNTER_EN_OUT && !ARMED_LED_OUT)
    else $error("reset did not abort and lock out");
  arm_finish_a: assert property ($rose(ARMED_LED_OUT) |->
    !LOCKOUT_OUT && COUNTER_EN_OUT && ($past(SAMPLE_CLK_IN) || $past(SAMPLE_CLK_IN, 2)))
    else $error("armed indicator without sampling clock or unlock");

  // Main scenarios reached
  verify_seen_c: cover property (take && fa == {`FN_VERIFY, `SUB_STATUS});
  trigger_seen_c: cover property (TRIGGER_OUT);
  armed_seen_c: cover property ($rose(ARMED_LED_OUT));
endmodule

// [sim/crate_controller_model.sv]
/*
  Crate controller model: one dataway function cycle per call.
  Assumes the station answers on the edge that takes the strobe.
*/
`timescale 1ns/100ps
module crate_controller_model (
  input  wire logic        clk_in,
  input  wire logic [11:0] r_in,
  input  wire logic        q_in,
  input  wire logic        x_in,
  output logic             strobe_out,
  output logic             n_out,
  output logic [4:0]       f_out,
  output logic [3:0]       a_out
);
  // Idle dataway at time zero
  initial
  begin
    strobe_out = 1'b0;
    n_out      = 1'b0;
    f_out      = 5'h1F;
    a_out      = 4'hF;
  end

  // Strobe held over one edge, answer taken there; code lines then inverted
  task automatic cycle(input logic [4:0] f, input logic [3:0] a, input logic n,
                       output logic [11:0] r, output logic q, output logic x);
    @(posedge clk_in);
    strobe_out <= 1'b1;
    n_out      <= n;
    f_out      <= f;
    a_out      <= a;
    @(posedge clk_in);
    strobe_out <= 1'b0;
    f_out      <= ~f;
    a_out      <= ~a;
    #1;
    r = r_in;
    q = q_in;
    x = x_in;
  endtask
endmodule

// [sim/crate_command_setup_verifier_bench.sv]
/*
  Self-checking bench for the crate command decoder and setup verifier.
  Assumes crate_cmd_defines.svh on the include path; counts are shortened.
*/
`timescale 1ns/100ps
`include "crate_cmd_defines.svh"
module crate_command_setup_verifier_bench;
  localparam int ARM_CYC = 100;
  localparam int VER_CYC = 200;
  localparam int RST_CYC = 300;
  localparam int LIMIT   = 6000;

  logic        sys_clk    = 1'b0;
  logic        resetn     = 1'b0;
  logic        acq_done   = 1'b0;
  logic        sample_clk = 1'b0;
  logic        setup_we   = 1'b0;
  logic [5:0]  setup_addr = 6'h00;
  logic [7:0]  setup_data = 8'h00;
  logic        strobe;
  logic        n_sel;
  logic [4:0]  f_code;
  logic [3:0]  a_code;
  logic [11:0] r_data;
  logic        q_resp;
  logic        x_resp;
  logic        lam;
  logic        lockout;
  logic        armed;
  logic        ok_led;
  logic        count_en;
  logic        count_clk;
  logic        trigger;
  logic [11:0] rv;
  logic        qv;
  logic        xv;
  logic [7:0]  exp_mem [36];
  int          failures    = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  always #10 sys_clk = ~sys_clk;

  crate_cmd_setup_verifier #(.ARM_CYCLES(ARM_CYC), .VERIFY_CYCLES(VER_CYC), .RESET_CYCLES(RST_CYC)) dut_u (
    .SYS_CLK_IN(sys_clk), .RESETN_IN(resetn), .STROBE_IN(strobe), .N_IN(n_sel), .F_IN(f_code),
    .A_IN(a_code), .ACQ_DONE_IN(acq_done), .SAMPLE_CLK_IN(sample_clk), .SETUP_WE_IN(setup_we),
    .SETUP_ADDR_IN(setup_addr), .SETUP_DATA_IN(setup_data), .R_OUT(r_data), .Q_OUT(q_resp),
    .X_OUT(x_resp), .LAM_OUT(lam), .LOCKOUT_OUT(lockout), .ARMED_LED_OUT(armed),
    .SETUP_OK_LED_OUT(ok_led), .COUNTER_EN_OUT(count_en), .COUNTER_CLK_OUT(count_clk), .TRIGGER_OUT(trigger));

  crate_controller_model ctl_u (
    .clk_in(sys_clk), .r_in(r_data), .q_in(q_resp), .x_in(x_resp),
    .strobe_out(strobe), .n_out(n_sel), .f_out(f_code), .a_out(a_code));

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      failures++;
      conclude();
    end
  end

  // Verdict and end of run
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compare tasks for values and single bits
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({11'h000, got}, {11'h000, exp});
  endtask

  // Stimulus helpers: command, wait, pulse, setup write, bounded unlock wait
  task automatic cmd(input logic [4:0] f, input logic [3:0] a);
    ctl_u.cycle(f, a, 1'b1, rv, qv, xv);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse(input logic smp);
    @(posedge sys_clk);
    sample_clk <= smp;
    acq_done   <= !smp;
    @(posedge sys_clk);
    sample_clk <= 1'b0;
    acq_done   <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [5:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    setup_we   <= 1'b1;
    setup_addr <= addr;
    setup_data <= data;
    @(posedge sys_clk);
    setup_we   <= 1'b0;
  endtask
  task automatic wait_unlock(output int n);
    n = 0;
    while (lockout === 1'b1 && n < 1000)
    begin
      tick(1);
      n++;
    end
  endtask

  task automatic t_ident();
    cmd(`FN_IDENT, 4'h0);
    chk_val(rv, `IDENT_CODE);
    chk_bit(qv, 1'b1);
    chk_bit(xv, 1'b1);
  endtask

  // Bad setup corrected, status, checksum, readback, clean re-verify, dual-clock faults
  task automatic t_verify();
    int         n;
    logic [7:0] sum;
    for (int i = 0; i < 36; i++)
      exp_mem[i] = 8'h00;
    exp_mem[`SU_SLOPE]    = `SLOPE_WINDOW;
    exp_mem[`SU_LEVEL_HI] = 8'h10;
    exp_mem[`SU_LEVEL_LO] = 8'h20;
    exp_mem[`SU_CHANS]    = 8'h03;
    exp_mem[`SU_SPS]      = 8'h0E;
    exp_mem[`SU_RATE1]    = 8'h12;
    for (int i = 0; i < 33; i++)
      wr(6'(i), exp_mem[i]);
    exp_mem[`SU_LEVEL_HI] = 8'h20;
    exp_mem[`SU_LEVEL_LO] = 8'h10;
    exp_mem[`SU_CHANS]    = 8'h04;
    exp_mem[`SU_SPS]      = 8'h00;
    exp_mem[`SU_RATE1]    = 8'h0E;
    exp_mem[`SU_SEG_LO]   = 8'h01;
    exp_mem[`SU_STATUS]   = 8'h41;
    sum = 8'h00;
    for (int i = 0; i < 34; i++)
      sum += exp_mem[i];
    exp_mem[`SU_CHECKSUM] = ~sum;
    cmd(`FN_VERIFY, `SUB_STATUS);
    chk_bit(lockout && ok_led, 1'b1);
    cmd(`FN_TEST_LOCK, 4'h0);
    chk_bit(qv, 1'b0);
    cmd(`FN_READ, 4'h1);
    chk_bit(qv, 1'b0);
    wait_unlock(n);
    chk_bit(n + 4 >= VER_CYC - 2 && n + 4 <= VER_CYC * 7 / 6, 1'b1);
    chk_bit(ok_led, 1'b0);
    for (int i = 0; i < 36; i++)
    begin
      cmd(`FN_READ, 4'h1);
      chk_val({4'h0, rv[7:0]}, {4'h0, exp_mem[(i + 33) % 36]});
    end
    cmd(`FN_VERIFY, `SUB_STATUS);
    wait_unlock(n);
    chk_bit(ok_led, 1'b1);
    cmd(`FN_READ, 4'h1);
    cmd(`FN_READ, `SUB_STATUS);
    cmd(`FN_READ, 4'h1);
    chk_val({4'h0, rv[7:0]}, 12'h000);
    wr(`SU_DUAL, 8'h01);
    wr(`SU_RATE1, `RATE_5MHZ);
    wr(`SU_RATE2, `RATE_2MHZ);
    wr(`SU_MEMSIZE, 8'h01);
    wr(`SU_SPS, 8'h05);
    cmd(`FN_VERIFY, `SUB_STATUS);
    wait_unlock(n);
    cmd(`FN_READ, 4'h1);
    chk_val({4'h0, rv[7:0]}, 12'h025);
  endtask

  // Request set, test, drive enable and disable, clear
  task automatic t_lam();
    cmd(`FN_TEST_RAW, 4'h0);
    chk_bit(qv, 1'b0);
    pulse(1'b0);
    cmd(`FN_TEST_RAW, 4'h0);
    chk_bit(qv, 1'b1);
    cmd(`FN_TEST_LAM, 4'h0);
    chk_bit(qv | lam, 1'b0);
    cmd(`FN_EN_LAM, 4'h0);
    tick(1);
    chk_bit(lam, 1'b1);
    cmd(`FN_TEST_LAM, 4'h0);
    chk_bit(qv, 1'b1);
    cmd(`FN_DIS_LAM, 4'h0);
    cmd(`FN_TEST_RAW, 4'h0);
    chk_bit(qv, 1'b1);
    cmd(`FN_CLEAR_LAM, 4'h0);
    cmd(`FN_TEST_RAW, 4'h0);
    chk_bit(qv, 1'b0);
  endtask

  // Arm ignores an early sampling clock, finishes on the first one after
  task automatic t_arm();
    cmd(`FN_ARM_RESET, 4'h0);
    chk_bit(lockout, 1'b1);
    cmd(`FN_TEST_LOCK, 4'h0);
    chk_bit(qv, 1'b0);
    pulse(1'b1);
    tick(ARM_CYC);
    chk_bit(lockout, 1'b1);
    chk_bit(armed, 1'b0);
    pulse(1'b1);
    tick(1);
    chk_bit(!lockout && armed && count_en, 1'b1);
    cmd(`FN_TEST_LOCK, 4'h0);
    chk_bit(qv, 1'b1);
  endtask

  // Trigger pulse, abort, then the extra data read clocks the counters
  task automatic t_trig();
    cmd(`FN_TRIG_ABORT, 4'h0);
    chk_bit(trigger, 1'b1);
    tick(1);
    chk_bit(trigger, 1'b0);
    cmd(`FN_TRIG_ABORT, 4'h1);
    chk_bit(count_en, 1'b0);
    cmd(`FN_READ, 4'h0);
    chk_bit(count_clk, 1'b1);
  endtask

  // Reset with request driven and armed indicator lit
  task automatic t_reset();
    int n;
    cmd(`FN_EN_LAM, 4'h0);
    pulse(1'b0);
    cmd(`FN_ARM_RESET, 4'h1);
    chk_bit(lockout && !armed, 1'b1);
    wait_unlock(n);
    chk_bit(n >= RST_CYC - 2 && n <= RST_CYC + 2, 1'b1);
    cmd(`FN_TEST_RAW, 4'h0);
    chk_bit(qv | lam, 1'b0);
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    t_ident();
    t_verify();
    t_lam();
    t_arm();
    t_trig();
    t_reset();
    conclude();
  end
endmodule

bind crate_cmd_setup_verifier crate_cmd_assertions #(
  .ARM_CYCLES(ARM_CYCLES), .VERIFY_CYCLES(VERIFY_CYCLES), .RESET_CYCLES(RESET_CYCLES)
) chk_u (
  .SYS_CLK_IN(SYS_CLK_IN), .RESETN_IN(RESETN_IN), .STROBE_IN(STROBE_IN), .N_IN(N_IN), .F_IN(F_IN),
  .A_IN(A_IN), .ACQ_DONE_IN(ACQ_DONE_IN), .SAMPLE_CLK_IN(SAMPLE_CLK_IN), .SETUP_WE_IN(SETUP_WE_IN),
  .SETUP_ADDR_IN(SETUP_ADDR_IN), .SETUP_DATA_IN(SETUP_DATA_IN), .R_OUT(R_OUT), .Q_OUT(Q_OUT),
  .X_OUT(X_OUT), .LAM_OUT(LAM_OUT), .LOCKOUT_OUT(LOCKOUT_OUT), .ARMED_LED_OUT(ARMED_LED_OUT),
  .SETUP_OK_LED_OUT(SETUP_OK_LED_OUT), .COUNTER_EN_OUT(COUNTER_EN_OUT),
  .COUNTER_CLK_OUT(COUNTER_CLK_OUT), .TRIGGER_OUT(TRIGGER_OUT));
